// File: hdl/sc_cfg_pkg.sv
// constants and field layout of the smart card configuration register slice
`default_nettype none
package sc_cfg_pkg;
    // byte offsets in configuration space
    localparam logic [7:0]  OFF_HDR_SUBSYS     = 8'h2c;
    localparam logic [7:0]  OFF_HDR_IRQ        = 8'h3c;
    localparam logic [7:0]  OFF_PM_CTRL        = 8'h48;
    localparam logic [7:0]  OFF_PM_BRIDGE_EXT  = 8'h4a;
    localparam logic [7:0]  OFF_PM_DATA        = 8'h4b;
    localparam logic [7:0]  OFF_GEN_CTRL       = 8'h4c;
    localparam logic [7:0]  OFF_SUBSYS_ALIAS   = 8'h50;
    localparam logic [7:0]  OFF_SOCKET_CFG     = 8'h58;
    // dword indices used by the decoder
    localparam logic [5:0]  DW_HDR_SUBSYS      = OFF_HDR_SUBSYS[7:2];
    localparam logic [5:0]  DW_HDR_IRQ         = OFF_HDR_IRQ[7:2];
    localparam logic [5:0]  DW_PM              = OFF_PM_CTRL[7:2];
    localparam logic [5:0]  DW_GEN_CTRL        = OFF_GEN_CTRL[7:2];
    localparam logic [5:0]  DW_SUBSYS_ALIAS    = OFF_SUBSYS_ALIAS[7:2];
    localparam logic [5:0]  DW_SOCKET_CFG      = OFF_SOCKET_CFG[7:2];
    // fixed read values
    localparam logic [7:0]  PM_BRIDGE_EXT_VAL  = 8'h00;
    localparam logic [7:0]  PM_DATA_VAL        = 8'h00;
    localparam logic [15:0] PM_CTRL_VAL        = 16'h0000;
    // general control layout
    localparam logic [7:0]  GC_RESET           = 8'h00;
    localparam logic [7:0]  GC_WRITE_MASK      = 8'h70;
    localparam int          GC_INT_SEL_LO      = 5;
    localparam int          GC_COLD_WAKE_BIT   = 4;
    // subsystem alias
    localparam logic [31:0] ALIAS_RESET        = 32'h00000000;
    // socket configuration layout
    localparam logic [31:0] SC_RESET           = 32'h00110001;
    localparam logic [31:0] SC_WRITE_MASK      = 32'hf1111011;
    localparam int          SC_SCRATCH_LO      = 28;
    localparam int          SC_CLASS_B_BIT     = 24;
    localparam int          SC_CLASS_A_BIT     = 20;
    localparam int          SC_EMV_BIT         = 16;
    localparam int          SC_PINS_BIT        = 12;
    localparam int          SC_WAKE_BIT        = 4;
    localparam int          SC_SOCKET_BIT      = 0;
    // header interrupt pin encoding: INTA reads as one
    localparam logic [7:0]  IRQ_PIN_BASE       = 8'h01;
    localparam int          IRQ_PIN_BYTE_LO    = 8;
    localparam int          STRAP_COUNT        = 4;
    localparam int          SYNC_STAGES        = 3;
endpackage
`default_nettype wire

// File: hdl/pin_sync3.sv
// three-stage input synchroniser with agreement filter
`default_nettype none
module pin_sync3 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    // asynchronous input and filtered output
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] stable_o
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] stable_reg;
    logic [WIDTH-1:0] stable_next;

    // stage one feeds stage two only; per-bit agreement of stages two and three
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            stable_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : stable_reg[i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s1_reg     <= '0;
            s2_reg     <= '0;
            s3_reg     <= '0;
            stable_reg <= '0;
        end else begin
            s1_reg     <= async_i;
            s2_reg     <= s1_reg;
            s3_reg     <= s2_reg;
            stable_reg <= stable_next;
        end
    end

    assign stable_o = stable_reg;
endmodule
`default_nettype wire

// File: hdl/sc_cfg_regs.sv
// configuration register slice of the smart card function
`default_nettype none
module sc_cfg_regs (
    // clock and resets
    input  wire logic                                clk_i,
    input  wire logic                                srst_i,
    input  wire logic                                pci_rst_i,
    // configuration access port
    input  wire logic                                cfg_req_i,
    input  wire logic                                cfg_we_i,
    input  wire logic [7:0]                          cfg_addr_i,
    input  wire logic [3:0]                          cfg_be_i,
    input  wire logic [31:0]                         cfg_wdata_i,
    output logic      [31:0]                         cfg_rdata_o,
    output logic                                     cfg_ack_o,
    // pins from the board
    input  wire logic [sc_cfg_pkg::STRAP_COUNT-1:0]  irq_routing_strap_i,
    input  wire logic                                card_present_i,
    // interrupt routing
    output logic      [1:0]                          irq_line_sel_o,
    output logic      [7:0]                          header_irq_pin_o,
    // power management
    output logic                                     pme_d3cold_cap_o,
    output logic                                     pme_wake_o,
    // socket controls and subsystem codes
    output logic                                     socket_on_o,
    output logic                                     card_class_a_ok_o,
    output logic                                     card_class_b_ok_o,
    output logic                                     emv_iface_on_o,
    output logic                                     card_pins_on_o,
    output logic      [15:0]                         subsys_device_code_o,
    output logic      [15:0]                         subsys_maker_code_o
);
    import sc_cfg_pkg::*;

    logic [7:0]             gen_ctrl_reg;
    logic [7:0]             gen_ctrl_next;
    logic [31:0]            alias_reg;
    logic [31:0]            alias_next;
    logic [31:0]            socket_reg;
    logic [31:0]            socket_next;
    logic [31:0]            rdata_reg;
    logic [31:0]            rdata_next;
    logic                   ack_reg;
    logic                   ack_next;
    logic [1:0]             route_reg;
    logic [1:0]             route_next;
    logic [7:0]             pin_reg;
    logic [7:0]             pin_next;
    logic                   wake_reg;
    logic                   wake_next;
    logic                   present_prev_reg;
    logic [STRAP_COUNT-1:0] strap_sync;
    logic                   present_sync;
    logic [5:0]             dword;
    logic                   wr;
    logic [31:0]            gc_wr_word;

    // straps and card detect come from pins
    pin_sync3 #(
        .WIDTH (STRAP_COUNT + 1)
    ) u_pin_sync (
        .clk_i    (clk_i),
        .srst_i   (srst_i),
        .async_i  ({card_present_i, irq_routing_strap_i}),
        .stable_o ({present_sync, strap_sync})
    );

    // byte-lane write limited to the writable bits
    function automatic logic [31:0] merge_write(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  be,
                                                input logic [31:0] mask);
        logic [31:0] lane;
        lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
        return (old_v & ~lane) | (new_v & lane);
    endfunction

    // lowest asserted strap wins when several are pulled
    function automatic logic [1:0] strap_route(input logic [STRAP_COUNT-1:0] s);
        logic [1:0] r;
        r = 2'h0;
        for (int i = STRAP_COUNT - 1; i >= 0; i--) begin
            if (s[i]) begin
                r = i[1:0];
            end
        end
        return r;
    endfunction

    assign dword = cfg_addr_i[7:2];
    assign wr    = cfg_req_i && cfg_we_i;
    // general control merged at full width, only the low byte is kept
    assign gc_wr_word = merge_write({24'h0, gen_ctrl_reg}, cfg_wdata_i, cfg_be_i, {24'h0, GC_WRITE_MASK});

    // register writes
    always_comb begin
        gen_ctrl_next = gen_ctrl_reg;
        alias_next    = alias_reg;
        socket_next   = socket_reg;
        if (wr) begin
            case (dword)
                DW_GEN_CTRL: begin
                    gen_ctrl_next = gc_wr_word[7:0];
                end
                DW_SUBSYS_ALIAS: begin
                    alias_next = merge_write(alias_reg, cfg_wdata_i, cfg_be_i, '1);
                end
                DW_SOCKET_CFG: begin
                    socket_next = merge_write(socket_reg, cfg_wdata_i, cfg_be_i, SC_WRITE_MASK);
                end
                default: begin
                    gen_ctrl_next = gen_ctrl_reg;
                end
            endcase
        end
    end

    // only the global reset clears these; pci reset has no say here
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            gen_ctrl_reg <= GC_RESET;
            alias_reg    <= ALIAS_RESET;
            socket_reg   <= SC_RESET;
        end else begin
            gen_ctrl_reg <= gen_ctrl_next;
            alias_reg    <= alias_next;
            socket_reg   <= socket_next;
        end
    end

    // read path, one cycle after the request
    always_comb begin
        rdata_next = 32'h0;
        ack_next   = cfg_req_i;
        if (cfg_req_i && !cfg_we_i) begin
            case (dword)
                DW_HDR_SUBSYS: begin
                    rdata_next = alias_reg;
                end
                DW_HDR_IRQ: begin
                    rdata_next[IRQ_PIN_BYTE_LO +: 8] = pin_reg;
                end
                DW_PM: begin
                    rdata_next = {PM_DATA_VAL, PM_BRIDGE_EXT_VAL, PM_CTRL_VAL};
                end
                DW_GEN_CTRL: begin
                    rdata_next = {24'h0, gen_ctrl_reg & GC_WRITE_MASK};
                end
                DW_SUBSYS_ALIAS: begin
                    rdata_next = alias_reg;
                end
                DW_SOCKET_CFG: begin
                    rdata_next = socket_reg & SC_WRITE_MASK;
                end
                default: begin
                    rdata_next = 32'h0;
                end
            endcase
        end
        if (pci_rst_i) begin
            ack_next   = 1'b0;
            rdata_next = 32'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_reg <= 32'h0;
            ack_reg   <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            ack_reg   <= ack_next;
        end
    end

    // interrupt routing and insertion wake
    always_comb begin
        route_next = gen_ctrl_next[GC_INT_SEL_LO +: 2];
        if (|strap_sync) begin
            route_next = strap_route(strap_sync);
        end
        pin_next  = IRQ_PIN_BASE + {6'h0, route_next};
        wake_next = socket_reg[SC_WAKE_BIT] && present_sync && !present_prev_reg;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            route_reg        <= 2'h0;
            pin_reg          <= IRQ_PIN_BASE;
            wake_reg         <= 1'b0;
            present_prev_reg <= 1'b0;
        end else begin
            route_reg        <= route_next;
            pin_reg          <= pin_next;
            wake_reg         <= wake_next;
            present_prev_reg <= present_sync;
        end
    end

    assign cfg_rdata_o          = rdata_reg;
    assign cfg_ack_o            = ack_reg;
    assign irq_line_sel_o       = route_reg;
    assign header_irq_pin_o     = pin_reg;
    assign pme_d3cold_cap_o     = gen_ctrl_reg[GC_COLD_WAKE_BIT];
    assign pme_wake_o           = wake_reg;
    assign socket_on_o          = socket_reg[SC_SOCKET_BIT];
    assign card_class_a_ok_o    = socket_reg[SC_CLASS_A_BIT];
    assign card_class_b_ok_o    = socket_reg[SC_CLASS_B_BIT];
    assign emv_iface_on_o       = socket_reg[SC_EMV_BIT];
    assign card_pins_on_o       = socket_reg[SC_PINS_BIT];
    assign subsys_device_code_o = alias_reg[31:16];
    assign subsys_maker_code_o  = alias_reg[15:0];

    // checks
    pm_reads_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (cfg_req_i && !cfg_we_i && !pci_rst_i && dword == DW_PM) |=> (cfg_ack_o && cfg_rdata_o == 32'h0))
        else $error("power management dword did not read zero");

    route_select_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (strap_sync == '0) |=> (irq_line_sel_o == $past(gen_ctrl_next[GC_INT_SEL_LO +: 2])))
        else $error("interrupt route does not follow programmed select");

    strap_override_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (strap_sync[0]) |=> (irq_line_sel_o == 2'h0))
        else $error("strap did not override interrupt select");

    header_pin_a: assert property (@(posedge clk_i) disable iff (srst_i)
        header_irq_pin_o == IRQ_PIN_BASE + {6'h0, irq_line_sel_o})
        else $error("header interrupt pin disagrees with route");

    gc_reserved_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (gen_ctrl_reg & ~GC_WRITE_MASK) == 8'h0)
        else $error("general control reserved bit set");

    alias_readback_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr && dword == DW_SUBSYS_ALIAS && cfg_be_i == 4'hf) ##1 !cfg_req_i ##1
        (cfg_req_i && !cfg_we_i && !pci_rst_i && dword == DW_HDR_SUBSYS)
        |=> (cfg_rdata_o == $past(cfg_wdata_i, 3)))
        else $error("subsystem alias not seen at header offset");

    pci_reset_keeps_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (pci_rst_i && !wr) |=> ($stable(socket_reg) && $stable(gen_ctrl_reg)))
        else $error("pci reset disturbed globally reset state");

    sc_reserved_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (socket_reg & ~SC_WRITE_MASK) == 32'h0)
        else $error("socket reserved bit set");

    insert_wake_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (pme_wake_o) |-> ($past(socket_reg[SC_WAKE_BIT]) && $past(present_sync) && !$past(present_prev_reg)))
        else $error("wake pulse without enabled insertion");

    socket_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr && dword == DW_SOCKET_CFG && cfg_be_i[0] && cfg_be_i[3])
        |=> (socket_on_o == $past(cfg_wdata_i[SC_SOCKET_BIT]) &&
             card_class_b_ok_o == $past(cfg_wdata_i[SC_CLASS_B_BIT])))
        else $error("socket enable or class b not written");

    // field writes reach their outputs or the scratch nibble one cycle later; cold wake holds otherwise
    cold_wake_cap_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr && dword == DW_GEN_CTRL && cfg_be_i[0])
        |=> (pme_d3cold_cap_o == $past(cfg_wdata_i[GC_COLD_WAKE_BIT])))
        else $error("cold wake capability not written");

    cold_wake_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !(wr && dword == DW_GEN_CTRL)
        |=> $stable(pme_d3cold_cap_o))
        else $error("cold wake capability changed without a write");

    class_a_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr && dword == DW_SOCKET_CFG && cfg_be_i[2])
        |=> (card_class_a_ok_o == $past(cfg_wdata_i[SC_CLASS_A_BIT])))
        else $error("class a support not written");

    emv_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr && dword == DW_SOCKET_CFG && cfg_be_i[2])
        |=> (emv_iface_on_o == $past(cfg_wdata_i[SC_EMV_BIT])))
        else $error("emv interface enable not written");

    pins_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr && dword == DW_SOCKET_CFG && cfg_be_i[1])
        |=> (card_pins_on_o == $past(cfg_wdata_i[SC_PINS_BIT])))
        else $error("card pin enable not written");

    scratch_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr && dword == DW_SOCKET_CFG && cfg_be_i[3])
        |=> (socket_reg[31:SC_SCRATCH_LO] == $past(cfg_wdata_i[31:SC_SCRATCH_LO])))
        else $error("scratch nibble not written");

    // state that only writes or the global reset may move, then wake gating and strap priority
    socket_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !(wr && dword == DW_SOCKET_CFG)
        |=> $stable(socket_reg))
        else $error("socket configuration changed without a write");

    alias_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !(wr && dword == DW_SUBSYS_ALIAS)
        |=> $stable({subsys_device_code_o, subsys_maker_code_o}))
        else $error("subsystem codes changed without a write");

    wake_gate_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !socket_reg[SC_WAKE_BIT]
        |=> !pme_wake_o)
        else $error("wake pulse while insertion wake is off");

    strap_high_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (strap_sync[1] && !strap_sync[0])
        |=> (irq_line_sel_o == 2'h1))
        else $error("second strap did not select line b");

    // read path against the visible register outputs, then reserved bits read as zero
    header_subsys_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (cfg_req_i && !cfg_we_i && !pci_rst_i && dword == DW_HDR_SUBSYS)
        |=> (cfg_rdata_o == {subsys_device_code_o, subsys_maker_code_o}))
        else $error("header subsystem read disagrees with codes");

    header_pin_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (cfg_req_i && !cfg_we_i && !pci_rst_i && dword == DW_HDR_IRQ)
        |=> (cfg_rdata_o[IRQ_PIN_BYTE_LO +: 8] == $past(header_irq_pin_o)))
        else $error("header interrupt pin read disagrees with output");

    gc_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (cfg_req_i && !cfg_we_i && !pci_rst_i && dword == DW_GEN_CTRL)
        |=> (cfg_rdata_o[31:7] == 25'h0 && cfg_rdata_o[3:0] == 4'h0))
        else $error("general control read shows reserved bits");

    sc_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (cfg_req_i && !cfg_we_i && !pci_rst_i && dword == DW_SOCKET_CFG)
        |=> ((cfg_rdata_o & ~SC_WRITE_MASK) == 32'h0))
        else $error("socket read shows reserved bits");
endmodule
`default_nettype wire

// File: bench/cfg_host_model.sv
// configuration host model that issues single accesses on the register port
`default_nettype none
module cfg_host_model (
    // clock
    input  wire logic        clk_i,
    // access port towards the register slice
    output logic             cfg_req_o,
    output logic             cfg_we_o,
    output logic [7:0]       cfg_addr_o,
    output logic [3:0]       cfg_be_o,
    output logic [31:0]      cfg_wdata_o,
    input  wire logic [31:0] cfg_rdata_i,
    input  wire logic        cfg_ack_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cfg_req_o   = 1'b0;
        cfg_we_o    = 1'b0;
        cfg_addr_o  = 8'h00;
        cfg_be_o    = 4'h0;
        cfg_wdata_o = 32'h00000000;
    end

    // one request per call; ack is a single-cycle pulse, so it is looked at every cycle
    task automatic access(input logic we, input logic [7:0] addr, input logic [3:0] be,
                          input logic [31:0] wdata, output logic [31:0] rdata, output logic ok);
        int n;
        ok    = 1'b0;
        rdata = 32'h00000000;
        @(negedge clk_i);
        cfg_req_o   = 1'b1;
        cfg_we_o    = we;
        cfg_addr_o  = addr;
        cfg_be_o    = be;
        cfg_wdata_o = wdata;
        @(posedge clk_i);
        @(negedge clk_i);
        cfg_req_o   = 1'b0;
        // released lines carry the inverse so a stale value never looks valid
        cfg_addr_o  = ~addr;
        cfg_be_o    = ~be;
        cfg_wdata_o = ~wdata;
        for (n = 0; n < 4 && !ok; n++) begin
            if (cfg_ack_i === 1'b1) begin
                ok    = 1'b1;
                rdata = cfg_rdata_i;
            end else begin
                @(negedge clk_i);
            end
        end
    endtask
endmodule
`default_nettype wire

// File: bench/sc_cfg_regs_tb.sv
// self-checking testbench of the smart card configuration register slice
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
module sc_cfg_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sc_cfg_pkg::*;

    logic                   clk_i = 1'b0;
    logic                   srst_i = 1'b1;
    logic                   pci_rst_i = 1'b0;
    logic                   cfg_req, cfg_we, cfg_ack;
    logic [7:0]             cfg_addr;
    logic [3:0]             cfg_be;
    logic [31:0]            cfg_wdata, cfg_rdata;
    logic [STRAP_COUNT-1:0] irq_routing_strap = '0;
    logic                   card_present = 1'b0;
    logic [1:0]             irq_line_sel_o;
    logic [7:0]             header_irq_pin_o;
    logic                   pme_d3cold_cap_o, pme_wake_o, socket_on_o, card_class_a_ok_o;
    logic                   card_class_b_ok_o, emv_iface_on_o, card_pins_on_o;
    logic [15:0]            subsys_device_code_o, subsys_maker_code_o;
    int                     mismatches = 0;
    int                     n_checks = 0;
    int                     wakes;
    logic [1:0]             sel;

    always #25 clk_i = ~clk_i;

    cfg_host_model host (.clk_i(clk_i), .cfg_req_o(cfg_req), .cfg_we_o(cfg_we), .cfg_addr_o(cfg_addr),
        .cfg_be_o(cfg_be), .cfg_wdata_o(cfg_wdata), .cfg_rdata_i(cfg_rdata), .cfg_ack_i(cfg_ack));

    sc_cfg_regs DUT (.clk_i(clk_i), .srst_i(srst_i), .pci_rst_i(pci_rst_i), .cfg_req_i(cfg_req),
        .cfg_we_i(cfg_we), .cfg_addr_i(cfg_addr), .cfg_be_i(cfg_be), .cfg_wdata_i(cfg_wdata),
        .cfg_rdata_o(cfg_rdata), .cfg_ack_o(cfg_ack), .irq_routing_strap_i(irq_routing_strap),
        .card_present_i(card_present), .irq_line_sel_o(irq_line_sel_o),
        .header_irq_pin_o(header_irq_pin_o), .pme_d3cold_cap_o(pme_d3cold_cap_o),
        .pme_wake_o(pme_wake_o), .socket_on_o(socket_on_o), .card_class_a_ok_o(card_class_a_ok_o),
        .card_class_b_ok_o(card_class_b_ok_o), .emv_iface_on_o(emv_iface_on_o),
        .card_pins_on_o(card_pins_on_o), .subsys_device_code_o(subsys_device_code_o),
        .subsys_maker_code_o(subsys_maker_code_o));

    task automatic final_report();
        if (mismatches == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic xfer(input logic we, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [31:0] r);
        logic ok;
        host.access(we, a, be, d, r, ok);
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[ERR] %0t no answer at offset %h", $time, a);
            final_report();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, be, d, r);
        `CHK(r, 32'h00000000);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 4'h0, 32'h00000000, r);
        `CHK(r, exp);
    endtask

    // straps pass a synchroniser, so the routing change is waited for under a bound
    task automatic wait_sel(input logic [1:0] exp);
        int n;
        for (n = 0; n < 12 && irq_line_sel_o !== exp; n++) @(negedge clk_i);
        `CHK(irq_line_sel_o, exp);
    endtask

    task automatic insert_card(output int c);
        c = 0;
        @(negedge clk_i);
        card_present = 1'b1;
        repeat (12) begin
            @(negedge clk_i);
            if (pme_wake_o === 1'b1) c++;
        end
        card_present = 1'b0;
        repeat (8) @(negedge clk_i);
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        srst_i = 1'b0;
        rd(8'h58, 32'h00110001);
        `CHK({socket_on_o, card_class_a_ok_o, emv_iface_on_o, card_class_b_ok_o}, 4'b1110);
        rd(8'h4c, 32'h00000000);
        rd(8'h50, 32'h00000000);
        wr(8'h48, 4'hf, 32'hffffffff);
        rd(8'h48, 32'h00000000);
        rd(8'h3c, 32'h00000100);
        rd(8'h60, 32'h00000000);
        wr(8'h58, 4'hf, 32'hffffffff);
        rd(8'h58, 32'hf1111011);
        `CHK({card_class_b_ok_o, card_pins_on_o}, 2'b11);
        wr(8'h58, 4'hf, 32'h00000000);
        rd(8'h58, 32'h00000000);
        `CHK({socket_on_o, card_class_a_ok_o, emv_iface_on_o, card_pins_on_o}, 4'b0000);
        for (int i = 0; i < 4; i++) begin
            sel = i[1:0];
            wr(8'h4c, 4'h1, {24'h0, 1'b1, sel, sel[0], 4'hf});
            rd(8'h4c, {24'h0, 1'b0, sel, sel[0], 4'h0});
            `CHK(irq_line_sel_o, sel);
            `CHK(header_irq_pin_o, 8'h01 + {6'h0, sel});
            rd(8'h3c, {16'h0, 8'h01 + {6'h0, sel}, 8'h00});
            `CHK(pme_d3cold_cap_o, sel[0]);
        end
        @(negedge clk_i);
        irq_routing_strap = 4'b0110;
        wait_sel(2'd1);
        irq_routing_strap = 4'b1001;
        wait_sel(2'd0);
        irq_routing_strap = 4'b0000;
        wait_sel(2'd3);
        wr(8'h58, 4'hf, 32'ha0000011);
        @(negedge clk_i);
        pci_rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        pci_rst_i = 1'b0;
        rd(8'h4c, 32'h00000070);
        rd(8'h58, 32'ha0000011);
        wr(8'h50, 4'hf, 32'h12345678);
        rd(8'h2c, 32'h12345678);
        `CHK({subsys_device_code_o, subsys_maker_code_o}, 32'h12345678);
        wr(8'h50, 4'hc, 32'haabbccdd);
        rd(8'h50, 32'haabb5678);
        insert_card(wakes);
        `CHK(wakes, 1);
        wr(8'h58, 4'hf, 32'h00000001);
        insert_card(wakes);
        `CHK(wakes, 0);
        @(negedge clk_i);
        srst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        srst_i = 1'b0;
        rd(8'h4c, 32'h00000000);
        rd(8'h58, 32'h00110001);
        rd(8'h50, 32'h00000000);
        final_report();
    end
endmodule
`default_nettype wire
